// ---- rtl/rpc_pkg.sv ----
// What this block does
// - Bundle id from UDP source or destination port
// - Port check location: none, source, destination, reserved
// - Switch clear forwards to CPU, set drops
// - Switch 8: CPU-destination ethertype packets
// - Switch 7: pseudowire OAM packets
// - Switch 6: unknown bundle identifier packets
// - Switch 5: checked UDP port matches neither
// - Switch 4: IP protocol neither UDP nor L2TPv3
// - Switch 3: ARP target is our address
// - Switch 2: ethertype not IP, MPLS, ARP or CPU type, or destination MAC not the station address
// - Switch 1: IP destination not ours
// - Switch 0: ARP target not ours
// - Control low half holds station address 47:32
// - Two pseudowire UDP ports, reset 0x085e each
// - Low word joins upper half into 48 bits
// - CPU ethertype register resets to 0x0800
//
// Purpose: Shared constants of the receive classifier filter
// Assumes: 32-bit AXI4-Lite register access, byte addressed
// Notes:   Offsets are byte addresses
package rpc_pkg;
    // ----------------------------------------------------------------
    // Register offsets
    // ----------------------------------------------------------------
    localparam logic [7:0]  OFS_MAC_LOW    = 8'h40;
    localparam logic [7:0]  OFS_CONTROL    = 8'h44;
    localparam logic [7:0]  OFS_UDP_PORTS  = 8'h48;
    localparam logic [7:0]  OFS_MAC2_LOW   = 8'h4c;
    localparam logic [7:0]  OFS_CPU_ETYPE  = 8'h54;
    localparam logic [7:0]  OFS_STATUS     = 8'h80;
    // ----------------------------------------------------------------
    // Control word fields
    // ----------------------------------------------------------------
    localparam int          POS_LEN_MISMATCH = 28;
    localparam int          POS_BN_LOC       = 27;
    localparam int          POS_PORT_LOC     = 25;
    localparam int          POS_SWITCH       = 16;
    localparam logic [31:0] CONTROL_MASK     = 32'h1fff_ffff;
    // ----------------------------------------------------------------
    // Reset values
    // ----------------------------------------------------------------
    localparam logic [31:0] RST_MAC_LOW   = 32'h0000_0000;
    localparam logic [31:0] RST_CONTROL   = 32'h0000_0000;
    localparam logic [31:0] RST_UDP_PORTS = 32'h085e_085e;
    localparam logic [31:0] RST_MAC2_LOW  = 32'h0000_0000;
    localparam logic [15:0] RST_CPU_ETYPE = 16'h0800;
    // ----------------------------------------------------------------
    // Protocol codes and bus answers
    // ----------------------------------------------------------------
    localparam logic [15:0] ETYPE_IP      = 16'h0800;
    localparam logic [15:0] ETYPE_MPLS    = 16'h8847;
    localparam logic [15:0] ETYPE_ARP     = 16'h0806;
    localparam logic [7:0]  PROTO_UDP     = 8'h11;
    localparam logic [7:0]  PROTO_L2TP    = 8'h73;
    localparam logic [1:0]  RESP_OKAY     = 2'h0;
    localparam logic [1:0]  RESP_DECERR   = 2'h3;
    // Port check location codes
    typedef enum logic [1:0] {
        RPC_LOC_NONE = 2'h0,
        RPC_LOC_SRC  = 2'h1,
        RPC_LOC_DST  = 2'h2,
        RPC_LOC_RSVD = 2'h3
    } rpc_loc_t;
    // Switch indices
    localparam int SW_ARP_OTHER = 0;
    localparam int SW_IP_OTHER  = 1;
    localparam int SW_ETYPE     = 2;
    localparam int SW_ARP_OURS  = 3;
    localparam int SW_PROTO     = 4;
    localparam int SW_PORT      = 5;
    localparam int SW_BUNDLE    = 6;
    localparam int SW_OAM       = 7;
    localparam int SW_CPU_ETYPE = 8;
endpackage

// ---- rtl/rpc_classifier.sv ----
// Purpose: Receive packet classifier filter with AXI4-Lite registers
// Assumes: Header fields arrive parsed, one summary per frame
// Notes:   Verdict comes one clock after the header strobe
`timescale 1ns/10ps
module rpc_classifier (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        nrst,
    // AXI4-Lite write address
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    // AXI4-Lite write data
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // AXI4-Lite read address
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    // AXI4-Lite read data
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // Parsed frame header from the MAC receive path
    input  wire logic        hdr_valid,
    input  wire logic        hdr_from_eth,
    input  wire logic [47:0] hdr_dst_mac,
    input  wire logic [15:0] hdr_ethertype,
    input  wire logic [7:0]  hdr_ip_proto,
    input  wire logic        hdr_ip_dst_ours,
    input  wire logic        hdr_arp_target_ours,
    input  wire logic [15:0] hdr_udp_src,
    input  wire logic [15:0] hdr_udp_dst,
    input  wire logic        hdr_bundle_known,
    input  wire logic        hdr_is_oam,
    // Verdict
    output logic             verdict_valid,
    output logic             verdict_keep,
    output logic             verdict_cpu,
    output logic             verdict_drop,
    output logic [15:0]      verdict_bundle_id
);
    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    logic [31:0] mac_low;
    logic [31:0] control;
    logic [31:0] udp_ports;
    logic [31:0] mac2_low;
    logic [15:0] cpu_etype;
    logic [7:0]  cnt_keep;
    logic [7:0]  cnt_cpu;
    logic [7:0]  cnt_drop;
    // Write path holding
    logic        aw_held;
    logic        w_held;
    logic [7:0]  aw_addr;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    logic        do_write;
    logic        wr_hit;
    // Field views
    logic [8:0]  switches;
    logic        bundle_id_port_select;
    logic [1:0]  port_check_location;
    logic [47:0] first_station_address;
    logic [15:0] pw_udp_port_a;
    logic [15:0] pw_udp_port_b;
    // Classification
    logic        next_keep;
    logic        next_cpu;
    logic        next_drop;
    logic [15:0] next_bundle;
    logic [15:0] checked_port;
    logic [31:0] next_rdata;
    logic [1:0]  next_rresp;

    // Byte-lane merge of a write into a register
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] strb);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                res[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return res;
    endfunction

    // ----------------------------------------------------------------
    // Field views of the control, station address and UDP port registers
    // ----------------------------------------------------------------
    assign switches     = control[rpc_pkg::POS_SWITCH +: 9];
    assign bundle_id_port_select = control[rpc_pkg::POS_BN_LOC];
    assign port_check_location   = control[rpc_pkg::POS_PORT_LOC +: 2];
    assign first_station_address = {control[15:0], mac_low};
    assign pw_udp_port_a         = udp_ports[15:0];
    assign pw_udp_port_b         = udp_ports[31:16];

    // ----------------------------------------------------------------
    // AXI4-Lite write channel
    // ----------------------------------------------------------------
    assign do_write = aw_held && w_held && !s_axi_bvalid;
    assign wr_hit   = (aw_addr == rpc_pkg::OFS_MAC_LOW) || (aw_addr == rpc_pkg::OFS_CONTROL)
                   || (aw_addr == rpc_pkg::OFS_UDP_PORTS) || (aw_addr == rpc_pkg::OFS_MAC2_LOW)
                   || (aw_addr == rpc_pkg::OFS_CPU_ETYPE) || (aw_addr == rpc_pkg::OFS_STATUS);

    // Address capture, taken in any order against data
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            aw_held       <= 1'b0;
            aw_addr       <= 8'h00;
            s_axi_awready <= 1'b0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held       <= 1'b1;
                aw_addr       <= {s_axi_awaddr[7:2], 2'h0};
                s_axi_awready <= 1'b0;
            end else if (do_write) begin
                aw_held <= 1'b0;
            end else begin
                s_axi_awready <= !aw_held && !s_axi_bvalid;
            end
        end
    end

    // Data capture
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            w_held       <= 1'b0;
            w_data       <= 32'h0000_0000;
            w_strb       <= 4'h0;
            s_axi_wready <= 1'b0;
        end else begin
            if (s_axi_wvalid && s_axi_wready) begin
                w_held       <= 1'b1;
                w_data       <= s_axi_wdata;
                w_strb       <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end else if (do_write) begin
                w_held <= 1'b0;
            end else begin
                s_axi_wready <= !w_held && !s_axi_bvalid;
            end
        end
    end

    // Write response after both halves
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= rpc_pkg::RESP_OKAY;
        end else if (do_write) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_hit ? rpc_pkg::RESP_OKAY : rpc_pkg::RESP_DECERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // Register storage; reserved control bits are never stored
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            mac_low   <= rpc_pkg::RST_MAC_LOW;
            control   <= rpc_pkg::RST_CONTROL;
            udp_ports <= rpc_pkg::RST_UDP_PORTS;
            mac2_low  <= rpc_pkg::RST_MAC2_LOW;
            cpu_etype <= rpc_pkg::RST_CPU_ETYPE;
        end else if (do_write) begin
            unique case (aw_addr)
                rpc_pkg::OFS_MAC_LOW:   mac_low   <= merge(mac_low, w_data, w_strb);
                rpc_pkg::OFS_CONTROL:   control   <= merge(control, w_data, w_strb) & rpc_pkg::CONTROL_MASK;
                rpc_pkg::OFS_UDP_PORTS: udp_ports <= merge(udp_ports, w_data, w_strb);
                rpc_pkg::OFS_MAC2_LOW:  mac2_low  <= merge(mac2_low, w_data, w_strb);
                rpc_pkg::OFS_CPU_ETYPE: begin
                    cpu_etype <= 16'(merge({cpu_etype, 16'h0000}, w_data, w_strb) >> 16);
                end
                default: begin
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // AXI4-Lite read channel
    // ----------------------------------------------------------------
    // Read mux; unmapped addresses answer zero with a decode error
    always_comb begin
        next_rdata = 32'h0000_0000;
        next_rresp = rpc_pkg::RESP_OKAY;
        unique case ({s_axi_araddr[7:2], 2'h0})
            rpc_pkg::OFS_MAC_LOW:   next_rdata = mac_low;
            rpc_pkg::OFS_CONTROL:   next_rdata = control;
            rpc_pkg::OFS_UDP_PORTS: next_rdata = udp_ports;
            rpc_pkg::OFS_MAC2_LOW:  next_rdata = mac2_low;
            rpc_pkg::OFS_CPU_ETYPE: next_rdata = {cpu_etype, 16'h0000};
            rpc_pkg::OFS_STATUS:    next_rdata = {8'h00, cnt_drop, cnt_cpu, cnt_keep};
            default:                next_rresp = rpc_pkg::RESP_DECERR;
        endcase
    end

    // Read handshake: one address in flight at a time
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= rpc_pkg::RESP_OKAY;
        end else begin
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid  <= 1'b1;
                s_axi_rdata   <= next_rdata;
                s_axi_rresp   <= next_rresp;
            end else if (s_axi_rvalid) begin
                if (s_axi_rready) begin
                    s_axi_rvalid <= 1'b0;
                end
            end else begin
                s_axi_arready <= 1'b1;
            end
        end
    end

    // ----------------------------------------------------------------
    // Classification
    // ----------------------------------------------------------------
    // Bundle id and checked port selection
    assign next_bundle  = bundle_id_port_select ? hdr_udp_dst : hdr_udp_src;
    assign checked_port = (port_check_location == rpc_pkg::RPC_LOC_SRC) ? hdr_udp_src : hdr_udp_dst;

    // Class decision; a set switch drops, a clear one forwards to the CPU
    always_comb begin
        logic       divert;
        logic [3:0] sw;
        logic       port_bad;
        divert   = 1'b1;
        sw       = 4'h0;
        port_bad = 1'b0;
        if (port_check_location == rpc_pkg::RPC_LOC_SRC || port_check_location == rpc_pkg::RPC_LOC_DST) begin
            port_bad = (checked_port != pw_udp_port_a) && (checked_port != pw_udp_port_b);
        end
        if (hdr_from_eth && hdr_dst_mac != first_station_address) begin
            divert = 1'b1;
            sw     = 4'(rpc_pkg::SW_ETYPE);
        end else if (hdr_ethertype == rpc_pkg::ETYPE_ARP) begin
            sw = hdr_arp_target_ours ? 4'(rpc_pkg::SW_ARP_OURS)
                                     : 4'(rpc_pkg::SW_ARP_OTHER);
        end else if (hdr_ethertype == rpc_pkg::ETYPE_IP) begin
            if (!hdr_ip_dst_ours) begin
                sw = 4'(rpc_pkg::SW_IP_OTHER);
            end else if (hdr_ip_proto != rpc_pkg::PROTO_UDP && hdr_ip_proto != rpc_pkg::PROTO_L2TP) begin
                sw = 4'(rpc_pkg::SW_PROTO);
            end else if (hdr_ip_proto == rpc_pkg::PROTO_UDP && port_bad) begin
                sw = 4'(rpc_pkg::SW_PORT);
            end else if (hdr_is_oam) begin
                sw = 4'(rpc_pkg::SW_OAM);
            end else if (!hdr_bundle_known) begin
                sw = 4'(rpc_pkg::SW_BUNDLE);
            end else begin
                divert = 1'b0;
            end
        end else if (hdr_ethertype == rpc_pkg::ETYPE_MPLS) begin
            if (hdr_is_oam) begin
                sw = 4'(rpc_pkg::SW_OAM);
            end else if (!hdr_bundle_known) begin
                sw = 4'(rpc_pkg::SW_BUNDLE);
            end else begin
                divert = 1'b0;
            end
        end else if (hdr_ethertype == cpu_etype) begin
            sw = 4'(rpc_pkg::SW_CPU_ETYPE);
        end else begin
            sw = 4'(rpc_pkg::SW_ETYPE);
        end
        next_keep = !divert;
        next_drop = divert && switches[sw];
        next_cpu  = divert && !switches[sw];
    end

    // Verdict register, one per header strobe
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            verdict_valid     <= 1'b0;
            verdict_keep      <= 1'b0;
            verdict_cpu       <= 1'b0;
            verdict_drop      <= 1'b0;
            verdict_bundle_id <= 16'h0000;
        end else begin
            verdict_valid <= hdr_valid;
            if (hdr_valid) begin
                verdict_keep      <= next_keep;
                verdict_cpu       <= next_cpu;
                verdict_drop      <= next_drop;
                verdict_bundle_id <= next_bundle;
            end
        end
    end

    // Wrapping verdict counters shown in the status word
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cnt_keep <= 8'h00;
            cnt_cpu  <= 8'h00;
            cnt_drop <= 8'h00;
        end else if (verdict_valid) begin
            cnt_keep <= cnt_keep + {7'h00, verdict_keep};
            cnt_cpu  <= cnt_cpu + {7'h00, verdict_cpu};
            cnt_drop <= cnt_drop + {7'h00, verdict_drop};
        end
    end

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    one_hot_a: assert property (@(posedge clk) disable iff (!nrst)
        verdict_valid |-> $onehot({verdict_keep, verdict_cpu, verdict_drop}))
        else $error("verdict is not exactly one of keep, cpu, drop");
    bundle_sel_a: assert property (@(posedge clk) disable iff (!nrst)
        hdr_valid |=> verdict_bundle_id == ($past(bundle_id_port_select) ? $past(hdr_udp_dst) : $past(hdr_udp_src)))
        else $error("bundle id taken from the wrong port");
    port_ignore_a: assert property (@(posedge clk) disable iff (!nrst)
        hdr_valid && port_check_location == rpc_pkg::RPC_LOC_NONE && hdr_ethertype == rpc_pkg::ETYPE_IP
        && hdr_ip_dst_ours && hdr_ip_proto == rpc_pkg::PROTO_UDP && !hdr_is_oam && hdr_bundle_known
        && !(hdr_from_eth && hdr_dst_mac != first_station_address) |=> verdict_keep)
        else $error("port check not skipped for code none");
    port_miss_a: assert property (@(posedge clk) disable iff (!nrst)
        hdr_valid && port_check_location == rpc_pkg::RPC_LOC_DST && hdr_ethertype == rpc_pkg::ETYPE_IP
        && hdr_ip_dst_ours && hdr_ip_proto == rpc_pkg::PROTO_UDP && hdr_udp_dst != pw_udp_port_a
        && hdr_udp_dst != pw_udp_port_b && !(hdr_from_eth && hdr_dst_mac != first_station_address)
        |=> verdict_drop == $past(switches[rpc_pkg::SW_PORT]) && !verdict_keep)
        else $error("port mismatch not routed by its switch");
    arp_ours_a: assert property (@(posedge clk) disable iff (!nrst)
        hdr_valid && hdr_ethertype == rpc_pkg::ETYPE_ARP && hdr_arp_target_ours
        && !(hdr_from_eth && hdr_dst_mac != first_station_address)
        |=> verdict_drop == $past(switches[rpc_pkg::SW_ARP_OURS]))
        else $error("ARP for our address misrouted");
    arp_other_a: assert property (@(posedge clk) disable iff (!nrst)
        hdr_valid && hdr_ethertype == rpc_pkg::ETYPE_ARP && !hdr_arp_target_ours
        && !(hdr_from_eth && hdr_dst_mac != first_station_address)
        |=> verdict_cpu == !$past(switches[rpc_pkg::SW_ARP_OTHER]))
        else $error("ARP for other address misrouted");
    ip_other_a: assert property (@(posedge clk) disable iff (!nrst)
        hdr_valid && hdr_ethertype == rpc_pkg::ETYPE_IP && !hdr_ip_dst_ours
        && !(hdr_from_eth && hdr_dst_mac != first_station_address)
        |=> verdict_drop == $past(switches[rpc_pkg::SW_IP_OTHER]))
        else $error("foreign IP destination misrouted");
    write_resp_a: assert property (@(posedge clk) disable iff (!nrst)
        do_write |=> s_axi_bvalid)
        else $error("write response missing after write");
    read_resp_a: assert property (@(posedge clk) disable iff (!nrst)
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && s_axi_rdata == $past(next_rdata))
        else $error("read answer missing or wrong");
    ctrl_rsvd_a: assert property (@(posedge clk) disable iff (!nrst)
        control[31:29] == 3'h0)
        else $error("reserved control bits stored");
    keep_cover: cover property (@(posedge clk) disable iff (!nrst) verdict_valid && verdict_keep);
    cpu_cover: cover property (@(posedge clk) disable iff (!nrst) verdict_valid && verdict_cpu);
    drop_cover: cover property (@(posedge clk) disable iff (!nrst) verdict_valid && verdict_drop);
    wr_cover: cover property (@(posedge clk) disable iff (!nrst) do_write && aw_addr == rpc_pkg::OFS_CONTROL);
endmodule

// ---- test/rpc_mac_rx_model.sv ----
// Purpose: Behavioural MAC receive path that hands parsed headers over
// Assumes: One header for each cycle that send is high
// Notes:   Fields show inverted leftovers outside the valid cycle
`timescale 1ns/10ps
module rpc_mac_rx_model #(
    parameter logic [15:0] ALT_ETYPE = 16'h9000
) (
    // Clock, reset and bench control
    input  wire logic        clk,
    input  wire logic        nrst,
    input  wire logic        send,
    input  wire logic [47:0] station,
    input  wire logic [31:0] ports,
    // Parsed header, flags are from eth, ip ours, arp ours, bundle known, oam
    output logic             hdr_valid,
    output logic [47:0]      hdr_dst_mac,
    output logic [15:0]      hdr_ethertype,
    output logic [7:0]       hdr_ip_proto,
    output logic [15:0]      hdr_udp_src,
    output logic [15:0]      hdr_udp_dst,
    output logic [4:0]       hdr_flags
);
    localparam logic [15:0] ETYPES [5] = '{16'h0800, 16'h8847, 16'h0806, ALT_ETYPE, 16'h86dd};
    localparam logic [7:0]  PROTOS [3] = '{8'h11, 8'h73, 8'h06};
    // Port field is a pseudowire port or a stray value
    function automatic logic [15:0] pick_port();
        int k;
        k = $urandom_range(2);
        return k == 0 ? ports[15:0] : k == 1 ? ports[31:16] : 16'($urandom);
    endfunction
    // One header a request, inverted leftovers otherwise
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            hdr_valid <= 1'b0;
            {hdr_dst_mac, hdr_ethertype, hdr_ip_proto, hdr_udp_src, hdr_udp_dst, hdr_flags} <= '0;
        end else if (send) begin
            hdr_valid     <= 1'b1;
            hdr_dst_mac   <= $urandom_range(1) ? station : {16'($urandom), 32'($urandom)};
            hdr_ethertype <= ETYPES[$urandom_range(4)];
            hdr_ip_proto  <= PROTOS[$urandom_range(2)];
            hdr_udp_src   <= pick_port();
            hdr_udp_dst   <= pick_port();
            hdr_flags     <= 5'($urandom);
        end else begin
            hdr_valid <= 1'b0;
            {hdr_dst_mac, hdr_ethertype, hdr_ip_proto, hdr_udp_src, hdr_udp_dst, hdr_flags} <=
                ~{hdr_dst_mac, hdr_ethertype, hdr_ip_proto, hdr_udp_src, hdr_udp_dst, hdr_flags};
        end
    end
endmodule

// ---- test/rpc_classifier_bench.sv ----
// Purpose: Self-checking bench of the receive classifier filter
// Assumes: Registers reached over AXI4-Lite, one access at a time
// Notes:   Every verdict is compared with an integer model
`timescale 1ns/10ps
module rpc_classifier_bench;
    localparam logic [15:0] ALT = 16'h9000;
    logic        clk, nrst, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, send, pend;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, hdr_valid, e_udp;
    logic        verdict_valid, verdict_keep, verdict_cpu, verdict_drop;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic [2:0]  e_kcd;
    logic [4:0]  flg;
    logic [7:0]  s_axi_awaddr, s_axi_araddr, hdr_ip_proto, n_keep, n_cpu, n_drop;
    logic [15:0] hdr_ethertype, hdr_udp_src, hdr_udp_dst, verdict_bundle_id, e_bid;
    logic [31:0] s_axi_wdata, s_axi_rdata, ctrl, mac_lo, ports;
    logic [47:0] hdr_dst_mac;
    int          n_mismatch, checks_done, sw;
    rpc_classifier dut (.clk, .nrst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
        .hdr_valid, .hdr_from_eth(flg[4]), .hdr_dst_mac, .hdr_ethertype, .hdr_ip_proto, .hdr_ip_dst_ours(flg[3]),
        .hdr_arp_target_ours(flg[2]), .hdr_udp_src, .hdr_udp_dst, .hdr_bundle_known(flg[1]),
        .hdr_is_oam(flg[0]), .verdict_valid, .verdict_keep, .verdict_cpu, .verdict_drop, .verdict_bundle_id);
    rpc_mac_rx_model #(.ALT_ETYPE(ALT)) far (.clk, .nrst, .send, .station({ctrl[15:0], mac_lo}), .ports,
        .hdr_valid, .hdr_dst_mac, .hdr_ethertype, .hdr_ip_proto, .hdr_udp_src, .hdr_udp_dst, .hdr_flags(flg));
    always #20 clk = ~clk;
    // Compare and count
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // Print counts and verdict, then end
    task automatic stop_test();
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    // Register write, address and data offered together
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        @(posedge clk);
        {s_axi_awaddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {a, d, 3'h7};
        forever begin
            @(posedge clk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) begin
                s_axi_bready <= 1'b0;
                chk(s_axi_bresp, r);
                break;
            end
        end
    endtask
    // Register read with expected data and response
    task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic [1:0] r);
        @(posedge clk);
        {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'h3};
        forever begin
            @(posedge clk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) begin
                s_axi_rready <= 1'b0;
                chk(s_axi_rdata, x);
                chk(s_axi_rresp, r);
                break;
            end
        end
    endtask
    // Switch that governs the frame, -1 when it is kept
    function automatic int pick_sw();
        logic [15:0] seen_port;
        seen_port = ctrl[26:25] == 2'h1 ? hdr_udp_src : hdr_udp_dst;
        if (flg[4] && hdr_dst_mac !== {ctrl[15:0], mac_lo}) return 2;
        if (hdr_ethertype == rpc_pkg::ETYPE_ARP) return flg[2] ? 3 : 0;
        if (hdr_ethertype == rpc_pkg::ETYPE_IP) begin
            if (!flg[3]) return 1;
            if (hdr_ip_proto != rpc_pkg::PROTO_UDP && hdr_ip_proto != rpc_pkg::PROTO_L2TP) return 4;
            if (hdr_ip_proto == rpc_pkg::PROTO_UDP && (ctrl[26] ^ ctrl[25]) && seen_port != ports[15:0]
                && seen_port != ports[31:16]) return 5;
        end
        if (hdr_ethertype == rpc_pkg::ETYPE_IP || hdr_ethertype == rpc_pkg::ETYPE_MPLS)
            return flg[0] ? 7 : flg[1] ? -1 : 6;
        return hdr_ethertype == ALT ? 8 : 2;
    endfunction
    // Verdict one clock after each header, checked against the model
    always @(posedge clk) if (nrst) begin
        chk(verdict_valid, pend);
        if (pend) chk({verdict_keep, verdict_cpu, verdict_drop}, e_kcd);
        if (pend && e_udp) chk(verdict_bundle_id, e_bid);
        pend = hdr_valid;
        if (hdr_valid) begin
            sw = pick_sw();
            e_kcd = sw < 0 ? 3'h4 : ctrl[16 + sw] ? 3'h1 : 3'h2;
            e_udp = sw < 0 && hdr_ethertype == rpc_pkg::ETYPE_IP && hdr_ip_proto == rpc_pkg::PROTO_UDP;
            e_bid = ctrl[27] ? hdr_udp_dst : hdr_udp_src;
            {n_keep, n_cpu, n_drop} = {n_keep + e_kcd[2], n_cpu + e_kcd[1], n_drop + e_kcd[0]};
        end
    end
    // Watchdog cuts a hang short
    initial begin
        #400us;
        n_mismatch++;
        stop_test();
    end
    // Main sequence
    initial begin
        {clk, nrst, send, pend, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, ctrl, mac_lo, n_keep, n_cpu, n_drop} = '0;
        ports = 32'h085e_085e;
        sw = $urandom(39308);
        repeat (3) @(posedge clk);
        nrst <= 1'b1;
        rd(8'h40, 32'h0, rpc_pkg::RESP_OKAY);
        rd(8'h44, 32'h0, rpc_pkg::RESP_OKAY);
        rd(8'h48, 32'h085e_085e, rpc_pkg::RESP_OKAY);
        rd(8'h4c, 32'h0, rpc_pkg::RESP_OKAY);
        rd(8'h54, 32'h0800_0000, rpc_pkg::RESP_OKAY);
        rd(8'h10, 32'h0, rpc_pkg::RESP_DECERR);
        wr(8'h20, 32'h1, rpc_pkg::RESP_DECERR);
        wr(8'h80, '1, rpc_pkg::RESP_OKAY);
        wr(8'h54, {ALT, 16'h0}, rpc_pkg::RESP_OKAY);
        for (int i = 0; i < 12; i++) begin
            ctrl = {4'h0, i[2], 2'(i), 25'($urandom)};
            {mac_lo, ports} = {$urandom, $urandom};
            wr(8'h40, mac_lo, rpc_pkg::RESP_OKAY);
            wr(8'h44, ctrl, rpc_pkg::RESP_OKAY);
            wr(8'h48, ports, rpc_pkg::RESP_OKAY);
            rd(8'h44, ctrl, rpc_pkg::RESP_OKAY);
            rd(8'h48, ports, rpc_pkg::RESP_OKAY);
            repeat (40) begin
                @(posedge clk);
                send <= 1'($urandom);
            end
            @(posedge clk);
            send <= 1'b0;
            repeat (3) @(posedge clk);
        end
        rd(8'h80, {8'h0, n_drop, n_cpu, n_keep}, rpc_pkg::RESP_OKAY);
        stop_test();
    end
endmodule
